// ---- licsr_pkg.sv ----
// Purpose: constants and carrier types for the local interrupt control/status block
// Assumes: 200 MHz mclk_i, register port with read data one cycle after the strobe
// Notes:   register offsets are byte addresses; all registers sit in the low bits
package licsr_pkg;

    // register map
    localparam logic [7:0]  ADDR_IEN_CTRL   = 8'h2C;
    localparam logic [7:0]  ADDR_VEC_CTRL   = 8'h30;
    localparam logic [7:0]  ADDR_STATUS     = 8'h34;

    // enable control register fields
    localparam int          IEN_PARITY      = 0;
    localparam int          IEN_UNUSED_L7   = 1;
    localparam int          IEN_VSB_VEC     = 2;
    localparam int          IEN_TICK_HIGH   = 3;
    localparam int          IEN_DUART       = 4;
    localparam int          IEN_VSB_UNVEC   = 5;
    localparam int          IEN_TICK_LOW    = 6;
    localparam int          IEN_GLOBAL      = 7;

    // vector control register fields
    localparam int          VEC_ABORT_EN    = 0;
    localparam int          VEC_ACFAIL_EN   = 1;
    localparam logic [7:0]  VEC_CTRL_MASK   = 8'hF3;

    // status register fields
    localparam int          ST_ACFAIL       = 0;
    localparam int          ST_ABORT        = 1;
    localparam int          ST_PARITY       = 2;
    localparam int          ST_VSB          = 3;
    localparam int          ST_TIMER_ZERO_TIMEOUT         = 4;
    localparam int          ST_TIMER_ONE_TIMEOUT         = 5;
    localparam int          ST_TIMER_TWO_TIMEOUT         = 6;
    localparam int          ST_TICK_HIGH    = 8;
    localparam int          ST_DUART_LIVE   = 9;
    localparam int          ST_VSB_LIVE     = 10;
    localparam int          ST_TICK_LOW     = 11;
    localparam int          ST_ABORT_LIVE   = 15;
    localparam int          ST_ACFAIL_LIVE  = 16;
    localparam int          ST_WATCHDOG     = 17;
    // bits that software clears by writing one
    localparam logic [23:0] ST_LATCH_MASK   = 24'h02097F;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    // low vector nibble per vectored source
    localparam logic [3:0]  VLO_ACFAIL      = 4'h0;
    localparam logic [3:0]  VLO_ABORT       = 4'h1;
    localparam logic [3:0]  VLO_PARITY      = 4'h2;
    localparam logic [3:0]  VLO_TIMER_ZERO_TIMEOUT        = 4'h3;
    localparam logic [3:0]  VLO_VSB         = 4'h4;
    localparam logic [3:0]  VLO_TIMER_ONE_TIMEOUT        = 4'h5;
    localparam logic [3:0]  VLO_TICK_HIGH   = 4'h6;
    localparam logic [3:0]  VLO_TICK_LOW    = 4'h7;

    // pending request index
    localparam int          NPEND           = 10;
    localparam int          P_ACFAIL        = 0;
    localparam int          P_ABORT         = 1;
    localparam int          P_PARITY        = 2;
    localparam int          P_TIMER_ZERO_TIMEOUT          = 3;
    localparam int          P_VSB_VEC       = 4;
    localparam int          P_TIMER_ONE_TIMEOUT          = 5;
    localparam int          P_TICK_HIGH     = 6;
    localparam int          P_DUART         = 7;
    localparam int          P_VSB_UNVEC     = 8;
    localparam int          P_TICK_LOW      = 9;

    // raw request inputs, synchronous; active high except tick_timer_request, which requests on its falling edge
    typedef struct packed {
        logic acfail;
        logic abort_btn;
        logic parity_fault;
        logic vsb_request;
        logic timer_zero_timeout;
        logic timer_one_timeout;
        logic timer_two_timeout;
        logic tick_timer_request;
        logic duart_request;
        logic watchdog_timeout;
    } licsr_src_type;

    // processor request and acknowledge answer
    typedef struct packed {
        logic [2:0] level;
        logic       ack_valid;
        logic       vector_drive;
        logic [7:0] vector;
    } licsr_irq_type;

    // block state apart from the watchdog flag
    typedef struct packed {
        logic [7:0]         ien;
        logic [7:0]         vctl;
        logic [23:0]        status;
        logic [NPEND-1:0]   pend;
        licsr_src_type      prev;
        logic [31:0]        rdata;
        licsr_irq_type      irq;
    } licsr_state_type;

endpackage : licsr_pkg

// ---- licsr_core.sv ----
// Purpose: interrupt enable, vector and status logic of a local resource controller
// Assumes: sources synchronous to mclk_i; acknowledge carries the level being taken
// Notes:   status writes are taken as full words; por_n_i only clears the watchdog flag
module licsr_core (
    // clock and resets
    input  wire logic                   mclk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   por_n_i,
    // register port
    input  wire logic [7:0]             addr_i,
    input  wire logic [31:0]            wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [31:0]            rdata_o,
    // interrupt sources and controls
    input  wire licsr_pkg::licsr_src_type src_i,
    input  wire logic                   parity_check_en_i,
    input  wire logic                   sysfail_live_i,
    // processor side
    input  wire logic                   iack_i,
    input  wire logic [2:0]             iack_level_i,
    output licsr_pkg::licsr_irq_type    irq_o,
    output logic                        watchdog_flag_o
);
    import licsr_pkg::*;

    licsr_state_type    s_reg;
    licsr_state_type    s_next;
    logic               wd_reg;
    logic               wd_next;
    logic [NPEND-1:0]   rise;
    logic [NPEND-1:0]   en;
    logic [NPEND-1:0]   act;
    logic [23:0]        st_view;
    logic [23:0]        st_set;
    logic               tick_fall;
    logic               st_wr;

    // edge detection and set terms
    always_comb begin
        tick_fall = s_reg.prev.tick_timer_request & ~src_i.tick_timer_request;
        st_wr     = wr_i && (addr_i == ADDR_STATUS);
        rise      = '0;
        rise[P_ACFAIL]    = src_i.acfail & ~s_reg.prev.acfail;
        rise[P_ABORT]     = src_i.abort_btn & ~s_reg.prev.abort_btn;
        rise[P_PARITY]    = parity_check_en_i & src_i.parity_fault
                            & ~s_reg.prev.parity_fault;
        rise[P_TIMER_ZERO_TIMEOUT]      = src_i.timer_zero_timeout & ~s_reg.prev.timer_zero_timeout;
        rise[P_VSB_VEC]   = src_i.vsb_request & ~s_reg.prev.vsb_request;
        rise[P_TIMER_ONE_TIMEOUT]      = src_i.timer_one_timeout & ~s_reg.prev.timer_one_timeout;
        rise[P_TICK_HIGH] = tick_fall;
        rise[P_TICK_LOW]  = tick_fall;
        st_set = '0;
        st_set[ST_ACFAIL]    = rise[P_ACFAIL];
        st_set[ST_ABORT]     = rise[P_ABORT];
        st_set[ST_PARITY]    = rise[P_PARITY];
        st_set[ST_VSB]       = rise[P_VSB_VEC];
        st_set[ST_TIMER_ZERO_TIMEOUT]      = rise[P_TIMER_ZERO_TIMEOUT];
        st_set[ST_TIMER_ONE_TIMEOUT]      = rise[P_TIMER_ONE_TIMEOUT];
        st_set[ST_TIMER_TWO_TIMEOUT]      = src_i.timer_two_timeout & ~s_reg.prev.timer_two_timeout;
        st_set[ST_TICK_HIGH] = tick_fall;
        st_set[ST_TICK_LOW]  = tick_fall;
    end

    // per source enables, all gated by global enable
    always_comb begin
        en = '0;
        en[P_ACFAIL]      = s_reg.vctl[VEC_ACFAIL_EN];
        en[P_ABORT]       = s_reg.vctl[VEC_ABORT_EN];
        en[P_PARITY]      = s_reg.ien[IEN_PARITY];
        en[P_TIMER_ZERO_TIMEOUT]        = s_reg.ien[IEN_PARITY];      // shares the level 7 enable
        en[P_VSB_VEC]     = s_reg.ien[IEN_VSB_VEC];
        en[P_TIMER_ONE_TIMEOUT]        = s_reg.ien[IEN_TICK_HIGH];   // shares level 6 enable
        en[P_TICK_HIGH]   = s_reg.ien[IEN_TICK_HIGH];
        en[P_DUART]       = s_reg.ien[IEN_DUART];
        en[P_VSB_UNVEC]   = s_reg.ien[IEN_VSB_UNVEC];
        en[P_TICK_LOW]    = s_reg.ien[IEN_TICK_LOW];
        act = s_reg.pend & en & {NPEND{s_reg.ien[IEN_GLOBAL]}};
    end

    // status as read: latched bits plus live levels
    always_comb begin
        st_view = s_reg.status;
        st_view[ST_DUART_LIVE]  = src_i.duart_request;
        st_view[ST_VSB_LIVE]    = src_i.vsb_request;
        st_view[13]             = sysfail_live_i;
        st_view[ST_ABORT_LIVE]  = src_i.abort_btn;
        st_view[ST_ACFAIL_LIVE] = src_i.acfail;
        st_view[ST_WATCHDOG]    = wd_reg;
    end

    // next state: registers, latches, pending, priority
    always_comb begin
        s_next = s_reg;
        s_next.prev = src_i;
        // register writes
        if (wr_i && addr_i == ADDR_IEN_CTRL) begin
            s_next.ien = wdata_i[7:0];
        end
        if (wr_i && addr_i == ADDR_VEC_CTRL) begin
            s_next.vctl = wdata_i[7:0] & VEC_CTRL_MASK;
        end
        // write one clears, a new event the same cycle wins
        if (st_wr) begin
            s_next.status = s_reg.status & ~(wdata_i[23:0] & ST_LATCH_MASK);
        end
        s_next.status = s_next.status | st_set;
        // edge pending bits only cleared by acknowledge
        s_next.pend = s_reg.pend | rise;
        s_next.pend[P_DUART]     = src_i.duart_request;   // level sources follow line
        s_next.pend[P_VSB_UNVEC] = src_i.vsb_request;
        // read data
        s_next.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                ADDR_IEN_CTRL: s_next.rdata = {24'h000000, s_reg.ien};
                ADDR_VEC_CTRL: s_next.rdata = {24'h000000, s_reg.vctl};
                ADDR_STATUS:   s_next.rdata = {8'h00, st_view};
                default:       s_next.rdata = '0;
            endcase
        end
        // request level, highest first
        s_next.irq.level = 3'h0;
        if (act[P_ACFAIL] | act[P_ABORT] | act[P_PARITY] | act[P_TIMER_ZERO_TIMEOUT]) begin
            s_next.irq.level = 3'h7;
        end else if (act[P_VSB_VEC] | act[P_TIMER_ONE_TIMEOUT] | act[P_TICK_HIGH]) begin
            s_next.irq.level = 3'h6;
        end else if (act[P_DUART]) begin
            s_next.irq.level = 3'h5;
        end else if (act[P_VSB_UNVEC]) begin
            s_next.irq.level = 3'h4;
        end else if (act[P_TICK_LOW]) begin
            s_next.irq.level = 3'h3;
        end
        // acknowledge: pick winner at that level, clear its pending
        s_next.irq.ack_valid    = 1'b0;
        s_next.irq.vector_drive = 1'b0;
        s_next.irq.vector       = '0;
        if (iack_i) begin
            s_next.irq.ack_valid = 1'b1;
            case (iack_level_i)
                3'h7: begin
                    if (act[P_ACFAIL]) begin
                        s_next.pend[P_ACFAIL] = 1'b0;
                        s_next.irq.vector_drive = 1'b1;
                        s_next.irq.vector = {s_reg.vctl[7:4], VLO_ACFAIL};
                    end else if (act[P_ABORT]) begin
                        s_next.pend[P_ABORT] = 1'b0;
                        s_next.irq.vector_drive = 1'b1;
                        s_next.irq.vector = {s_reg.vctl[7:4], VLO_ABORT};
                    end else if (act[P_PARITY]) begin
                        s_next.pend[P_PARITY] = 1'b0;
                        s_next.irq.vector_drive = 1'b1;
                        s_next.irq.vector = {s_reg.vctl[7:4], VLO_PARITY};
                    end else if (act[P_TIMER_ZERO_TIMEOUT]) begin
                        s_next.pend[P_TIMER_ZERO_TIMEOUT] = 1'b0;
                        s_next.irq.vector_drive = 1'b1;
                        s_next.irq.vector = {s_reg.vctl[7:4], VLO_TIMER_ZERO_TIMEOUT};
                    end
                end
                3'h6: begin
                    if (act[P_VSB_VEC]) begin
                        s_next.pend[P_VSB_VEC] = 1'b0;
                        s_next.irq.vector_drive = 1'b1;
                        s_next.irq.vector = {s_reg.vctl[7:4], VLO_VSB};
                    end else if (act[P_TIMER_ONE_TIMEOUT]) begin
                        s_next.pend[P_TIMER_ONE_TIMEOUT] = 1'b0;
                        s_next.irq.vector_drive = 1'b1;
                        s_next.irq.vector = {s_reg.vctl[7:4], VLO_TIMER_ONE_TIMEOUT};
                    end else if (act[P_TICK_HIGH]) begin
                        s_next.pend[P_TICK_HIGH] = 1'b0;
                        s_next.irq.vector_drive = 1'b1;
                        s_next.irq.vector = {s_reg.vctl[7:4], VLO_TICK_HIGH};
                    end
                end
                3'h3: begin
                    if (act[P_TICK_LOW]) begin
                        s_next.pend[P_TICK_LOW] = 1'b0;
                        s_next.irq.vector_drive = 1'b1;
                        s_next.irq.vector = {s_reg.vctl[7:4], VLO_TICK_LOW};
                    end
                end
                // level 5 and 4: requester supplies vector
                default: begin
                    s_next.irq.vector_drive = 1'b0;
                end
            endcase
        end
        // watchdog flag: set wins over clear
        wd_next = wd_reg;
        if (st_wr && wdata_i[ST_WATCHDOG]) begin
            wd_next = 1'b0;
        end
        if (src_i.watchdog_timeout) begin
            wd_next = 1'b1;
        end
    end

    // state register
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // watchdog flag only sees power-on reset
    always_ff @(posedge mclk_i or negedge por_n_i) begin
        if (!por_n_i) begin
            wd_reg <= 1'b0;
        end else begin
            wd_reg <= wd_next;
        end
    end

    assign rdata_o         = s_reg.rdata;
    assign irq_o           = s_reg.irq;
    assign watchdog_flag_o = wd_reg;

    // checks
    AST_GLOBAL_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !s_reg.ien[IEN_GLOBAL] |=> irq_o.level == 3'h0)
        else $error("request raised with global enable off");
    AST_ACFAIL_LATCH: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(src_i.acfail) ##1 1'b1 |-> s_reg.status[ST_ACFAIL])
        else $error("acfail edge not latched");
    AST_PARITY_GATE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !parity_check_en_i && !s_reg.status[ST_PARITY] |=> !s_reg.status[ST_PARITY])
        else $error("parity status set while checking disabled");
    AST_STATUS_CLEAR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_wr && wdata_i[ST_VSB] && !st_set[ST_VSB] |=> !s_reg.status[ST_VSB])
        else $error("latched status bit not cleared by write of one");
    AST_LIVE_DUART: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rd_i && addr_i == ADDR_STATUS |=> rdata_o[ST_DUART_LIVE] == $past(src_i.duart_request))
        else $error("duart live bit wrong");
    AST_CLEAR_KEEPS_PEND: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_wr && s_reg.pend[P_TIMER_ONE_TIMEOUT] && !iack_i |=> s_reg.pend[P_TIMER_ONE_TIMEOUT])
        else $error("status clear withdrew pending request");
    AST_IACK_KEEPS_STATUS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        iack_i && !st_wr && s_reg.status[ST_ABORT] |=> s_reg.status[ST_ABORT])
        else $error("acknowledge cleared status");
    AST_UNVEC_NO_DRIVE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        iack_i && iack_level_i == 3'h4 |=> irq_o.ack_valid && !irq_o.vector_drive)
        else $error("vector driven for level 4");
    AST_VEC_UPPER: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        irq_o.vector_drive |-> irq_o.vector[7:4] == $past(s_reg.vctl[7:4]))
        else $error("vector upper nibble wrong");
    AST_TICK_FALL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $fell(src_i.tick_timer_request) |=> s_reg.status[ST_TICK_HIGH])
        else $error("tick falling edge not latched");

endmodule : licsr_core

// ---- licsr_cpu_model.sv ----
// Purpose: local processor model that runs interrupt acknowledge cycles
// Assumes: acknowledge answer comes one cycle after the taken iack pulse
// Notes:   answers alternately at once and after three idle cycles
module licsr_cpu_model (
    // clock and reset
    input  wire logic                     mclk_i,
    input  wire logic                     rst_n_i,
    // bench permission and block request
    input  wire logic                     go_i,
    input  wire licsr_pkg::licsr_irq_type irq_i,
    // acknowledge cycle
    output logic                          iack_o,
    output logic [2:0]                    iack_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import licsr_pkg::*;

    // vector of the external requester, value arbitrary
    localparam logic [7:0] EXT_VEC = 8'h5A;
    logic [7:0]            taken_vec;
    logic                  slow;

    // one acknowledge per request seen while the bench allows it
    initial begin
        iack_o = 1'b0;
        iack_level_o = 3'h0;
        slow = 1'b0;
        forever begin
            @(posedge mclk_i);
            if (rst_n_i && go_i && irq_i.level != 3'h0) begin
                if (slow) repeat (3) @(posedge mclk_i);
                slow = ~slow;
                iack_o <= 1'b1;
                iack_level_o <= irq_i.level;
                @(posedge mclk_i);
                iack_o <= 1'b0;
                // level no longer qualified: show a changed value
                iack_level_o <= ~iack_level_o;
                repeat (4) begin
                    @(posedge mclk_i);
                    // unvectored answer: the far requester puts its own vector
                    if (irq_i.ack_valid === 1'b1) taken_vec = irq_i.vector_drive ? irq_i.vector : EXT_VEC;
                end
            end
        end
    end
endmodule : licsr_cpu_model

// ---- licsr_core_tb_top.sv ----
// Purpose: self-checking bench of the interrupt control and status block
// Assumes: read data one cycle after the strobe, ack answer one cycle after iack
// Notes:   reads and acknowledges are noted in queues and checked by one monitor
module licsr_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import licsr_pkg::*;

    logic          mclk_i, rst_n_i, por_n_i, wr_i, rd_i, rd_d, go;
    logic          parity_check_en_i, sysfail_live_i, iack_i, watchdog_flag_o;
    logic [7:0]    addr_i;
    logic [31:0]   wdata_i, rdata_o, rng, re;
    logic [2:0]    iack_level_i;
    logic [9:0]    idle;
    logic [8:0]    ae;
    licsr_src_type src_i;
    licsr_irq_type irq_o;
    logic [31:0]   rq [$];
    logic [8:0]    aq [$];
    int            bad_count, compares, acks, cyc, i;

    // one line per vectored or latched source
    localparam logic [9:0]  T_SRC [9] = '{10'h200, 10'h100, 10'h080, 10'h020, 10'h010,
                                          10'h040, 10'h004, 10'h004, 10'h008};
    localparam logic [7:0]  T_IEN [9] = '{8'h80, 8'h80, 8'h81, 8'h81, 8'h88, 8'h84, 8'h88,
                                          8'hC0, 8'h80};
    localparam logic [1:0]  T_VC  [9] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
    localparam logic [2:0]  T_LVL [9] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h6, 3'h6, 3'h6, 3'h3, 3'h0};
    localparam logic [3:0]  T_LO  [9] = '{VLO_ACFAIL, VLO_ABORT, VLO_PARITY, VLO_TIMER_ZERO_TIMEOUT, VLO_TIMER_ONE_TIMEOUT,
                                          VLO_VSB, VLO_TICK_HIGH, VLO_TICK_LOW, 4'h0};
    localparam logic [23:0] T_ST  [9] = '{24'h1, 24'h2, 24'h4, 24'h10, 24'h20, 24'h8, 24'h900,
                                          24'h900, 24'h40};

    licsr_core i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_i(src_i),
        .parity_check_en_i(parity_check_en_i), .sysfail_live_i(sysfail_live_i),
        .iack_i(iack_i), .iack_level_i(iack_level_i), .irq_o(irq_o),
        .watchdog_flag_o(watchdog_flag_o));

    licsr_cpu_model i_cpu (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .go_i(go), .irq_i(irq_o),
        .iack_o(iack_i), .iack_level_o(iack_level_i));

    // 200 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic finish_test();
        if (aq.size() != 0 || rq.size() != 0) bad_count++;
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        compares++;
        if (got !== e) begin
            bad_count++;
            $display("BAD %0t %h %h", $time, got, e);
        end
    endtask : chk

    // full word writes and reads, one cycle strobes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
    endtask : rd

    task automatic put(input logic [9:0] v, input int n);
        @(posedge mclk_i);
        src_i <= v;
        repeat (n) @(posedge mclk_i);
    endtask : put

    task automatic pulse(input logic [9:0] m);
        put(idle ^ m, 0);
        put(idle, 4);
    endtask : pulse

    task automatic ack(input logic [8:0] e);
        int n;
        aq.push_back(e);
        n = acks;
        go <= 1'b1;
        for (int k = 0; k < 40 && acks == n; k++) @(posedge mclk_i);
        go <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask : ack

    // monitor: read data one cycle after the strobe, ack answers, hang limit
    always @(posedge mclk_i) begin
        if (rd_d === 1'b1) begin
            re = rq.size() ? rq.pop_front() : 32'hDEADBEEF;
            compares++;
            if (rdata_o !== re) begin
                bad_count++;
                $display("BAD %0t %h %h", $time, rdata_o, re);
            end
        end
        rd_d <= rd_i;
        if (irq_o.ack_valid === 1'b1) begin
            ae = aq.size() ? aq.pop_front() : 9'h1FF;
            compares++;
            acks++;
            if (irq_o.vector_drive !== ae[8] || (ae[8] && irq_o.vector !== ae[7:0])) begin
                bad_count++;
                $display("BAD %0t %h %h", $time, {irq_o.vector_drive, irq_o.vector}, ae);
            end
        end
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            finish_test();
        end
    end

    // main sequence
    initial begin
        rst_n_i = 1'b0;
        por_n_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        go = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        parity_check_en_i = 1'b0;
        sysfail_live_i = 1'b0;
        idle = 10'h004;
        src_i = idle;
        rng = 32'h2;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        por_n_i <= 1'b1;
        rd(ADDR_IEN_CTRL, {24'h0, CTRL_RESET});
        rd(ADDR_VEC_CTRL, {24'h0, CTRL_RESET});
        rd(ADDR_STATUS, 32'h0);
        wr(8'h38, 32'hFFFFFFFF);
        rd(8'h38, 32'h0);
        wr(ADDR_VEC_CTRL, 32'hFF);
        rd(ADDR_VEC_CTRL, 32'hF3);
        // masked sources still latch status
        wr(ADDR_IEN_CTRL, 32'h01);
        wr(ADDR_VEC_CTRL, 32'h03);
        pulse(10'h200);
        pulse(10'h080);
        chk({29'h0, irq_o.level}, 32'h0);
        rd(ADDR_STATUS, 32'h1);
        wr(ADDR_IEN_CTRL, 32'h80);
        wr(ADDR_VEC_CTRL, 32'h00);
        pulse(10'h100);
        chk({29'h0, irq_o.level}, 32'h0);
        rd(ADDR_STATUS, 32'h3);
        wr(ADDR_STATUS, 32'h2);
        rd(ADDR_STATUS, 32'h1);
        wr(ADDR_STATUS, 32'h1);
        parity_check_en_i <= 1'b1;
        // each source: request, vector, status clear before or after ack
        for (i = 0; i < 9; i++) begin
            rng = xs(rng);
            wr(ADDR_IEN_CTRL, {24'h0, T_IEN[i]});
            wr(ADDR_VEC_CTRL, {24'h0, rng[7:4], 2'b00, T_VC[i]});
            pulse(T_SRC[i]);
            chk({29'h0, irq_o.level}, {29'h0, T_LVL[i]});
            if (i % 2 == 0) begin
                wr(ADDR_STATUS, {8'h0, T_ST[i]});
                rd(ADDR_STATUS, 32'h0);
                chk({29'h0, irq_o.level}, {29'h0, T_LVL[i]});
            end
            if (T_LVL[i] != 3'h0) ack({1'b1, rng[7:4], T_LO[i]});
            chk({29'h0, irq_o.level}, 32'h0);
            rd(ADDR_STATUS, (i % 2) ? {8'h0, T_ST[i]} : 32'h0);
            wr(ADDR_STATUS, {8'h0, T_ST[i]});
        end
        // level-following sources answered without a vector
        wr(ADDR_IEN_CTRL, 32'h90);
        put(idle | 10'h002, 4);
        chk({29'h0, irq_o.level}, 32'h5);
        wr(ADDR_STATUS, 32'h200);
        rd(ADDR_STATUS, 32'h200);
        ack(9'h000);
        put(idle, 4);
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_IEN_CTRL, 32'hA0);
        put(idle | 10'h040, 4);
        chk({29'h0, irq_o.level}, 32'h4);
        rd(ADDR_STATUS, 32'h408);
        ack(9'h000);
        put(idle, 4);
        wr(ADDR_STATUS, 32'h8);
        rd(ADDR_STATUS, 32'h0);
        // live bits ignore writes
        wr(ADDR_IEN_CTRL, 32'h0);
        sysfail_live_i <= 1'b1;
        put(idle | 10'h300, 4);
        rd(ADDR_STATUS, 32'h1A003);
        wr(ADDR_STATUS, 32'hFFFFFFFF);
        rd(ADDR_STATUS, 32'h1A000);
        sysfail_live_i <= 1'b0;
        put(idle, 4);
        rd(ADDR_STATUS, 32'h0);
        // watchdog flag survives reset, power-on clears it
        pulse(10'h001);
        chk({31'h0, watchdog_flag_o}, 32'h1);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(ADDR_STATUS, 32'h20000);
        wr(ADDR_STATUS, 32'h20000);
        rd(ADDR_STATUS, 32'h0);
        pulse(10'h001);
        por_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        por_n_i <= 1'b1;
        chk({31'h0, watchdog_flag_o}, 32'h0);
        rd(ADDR_STATUS, 32'h0);
        repeat (3) @(posedge mclk_i);
        finish_test();
    end
endmodule : licsr_core_tb_top
